// ---- rtl/cfs_pkg.sv ----
package cfs_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int FLAG_W = 11;
  localparam int IPL_W  = 3;
  localparam int SP_W   = 16;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BIT_C    = 0;
  localparam int BIT_D    = 1;
  localparam int BIT_Z    = 2;
  localparam int BIT_S    = 3;
  localparam int BIT_B    = 4;
  localparam int BIT_O    = 5;
  localparam int BIT_I    = 6;
  localparam int BIT_U    = 7;
  localparam int BIT_IPL  = 8;
  localparam int BIT_RSVD = 11;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_SAVED = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_ISP   = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_USP   = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_STAT  = 4'h4;

  // ------------------------------------------------------------
  // reset values and constants
  // ------------------------------------------------------------
  localparam logic [FLAG_W-1:0] FLAGS_RST  = 11'h000;
  localparam logic [SP_W-1:0]   SP_RST     = 16'h0000;
  localparam logic [5:0]        TRAP_U_MAX = 6'h1f;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic             valid;
    logic [4:0]       mask;
    logic             carry;
    logic             zero;
    logic             sign;
    logic             ovf;
  } cfs_alu_t;

  typedef struct packed {
    logic             ack;
    logic             hw;
    logic [5:0]       num;
  } cfs_ack_t;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_SAVED = 3'b010,
    ST_RET   = 3'b100
  } cfs_state_t;

endpackage

// ---- rtl/cfs_prio_cmp.sv ----
`timescale 1ns/1ps
module cfs_prio_cmp (
  // request
  input  wire logic                     i_req,
  input  wire logic [cfs_pkg::IPL_W-1:0] i_req_prio,
  // current state
  input  wire logic                     i_ie,
  input  wire logic [cfs_pkg::IPL_W-1:0] i_ipl,
  // result
  output wire logic                     o_accept
);
  wire higher = (i_req_prio > i_ipl);
  assign o_accept = i_req & i_ie & higher;
endmodule

// ---- rtl/cfs_sp_bank.sv ----
`timescale 1ns/1ps
module cfs_sp_bank (
  // clock and reset
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rst_n,
  // write
  input  wire logic                    i_wr,
  input  wire logic                    i_sel,
  input  wire logic [cfs_pkg::SP_W-1:0] i_wdata,
  // read
  input  wire logic                    i_rsel,
  output logic      [cfs_pkg::SP_W-1:0] o_rdata
);
  // ------------------------------------------------------------
  // two stack pointers
  // ------------------------------------------------------------
  logic [cfs_pkg::SP_W-1:0] sp_reg [2];

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_sp
      always_ff @(posedge i_sys_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
          sp_reg[g] <= cfs_pkg::SP_RST;
        else if (i_wr && (i_sel == 1'(g)))
          sp_reg[g] <= i_wdata;
      end
    end
  endgenerate

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_rdata <= cfs_pkg::SP_RST;
    else
      o_rdata <= sp_reg[i_rsel];
  end
endmodule

// ---- rtl/cfs_status_reg.sv ----
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module cfs_status_reg (
  // clock and reset
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_rst_n,
  // register port
  input  wire logic [cfs_pkg::ADDR_W-1:0]    i_addr,
  input  wire logic [cfs_pkg::DATA_W-1:0]    i_wdata,
  input  wire logic                          i_wr,
  input  wire logic                          i_rd,
  output logic      [cfs_pkg::DATA_W-1:0]    o_rdata,
  // arithmetic unit
  input  wire cfs_pkg::cfs_alu_t             i_alu,
  // interrupt
  input  wire logic                          i_irq_req,
  input  wire logic [cfs_pkg::IPL_W-1:0]     i_irq_prio,
  input  wire cfs_pkg::cfs_ack_t             i_ack,
  input  wire logic                          i_ret,
  // stack pointer access
  input  wire logic                          i_sp_wr,
  input  wire logic [cfs_pkg::SP_W-1:0]      i_sp_wdata,
  // state outputs
  output logic      [cfs_pkg::FLAG_W-1:0]    o_flags,
  output logic                               o_bank,
  output logic                               o_irq_accept,
  output logic      [cfs_pkg::SP_W-1:0]      o_sp
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [cfs_pkg::FLAG_W-1:0] flags_reg;
  logic [cfs_pkg::FLAG_W-1:0] flags_next;
  logic [cfs_pkg::FLAG_W-1:0] saved_reg;
  cfs_pkg::cfs_state_t        state_reg;
  cfs_pkg::cfs_state_t        state_next;
  logic [cfs_pkg::DATA_W-1:0] rdata_next;
  logic [cfs_pkg::SP_W-1:0]   sp_rdata;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire wr_flags = i_wr & (i_addr == cfs_pkg::OFF_FLAGS);
  wire wr_isp   = i_wr & (i_addr == cfs_pkg::OFF_ISP);
  wire wr_usp   = i_wr & (i_addr == cfs_pkg::OFF_USP);
  wire sp_u     = flags_reg[cfs_pkg::BIT_U];
  wire sp_wr    = i_sp_wr | wr_isp | wr_usp;
  wire sp_sel   = i_sp_wr ? sp_u : wr_usp;
  wire [cfs_pkg::SP_W-1:0] sp_wdata = i_sp_wr ? i_sp_wdata : i_wdata;
  wire rsel     = (i_rd && i_addr == cfs_pkg::OFF_ISP) ? 1'b0 :
                  (i_rd && i_addr == cfs_pkg::OFF_USP) ? 1'b1 : sp_u;
  wire ack_u_clr = i_ack.ack & (i_ack.hw | (i_ack.num <= cfs_pkg::TRAP_U_MAX));
  wire [cfs_pkg::IPL_W-1:0] processor_priority_level = flags_reg[cfs_pkg::BIT_IPL +: cfs_pkg::IPL_W];
  wire accept;

  // ------------------------------------------------------------
  // next flags
  // ------------------------------------------------------------
  always_comb
  begin
    flags_next = flags_reg;
    if (i_ret)
      flags_next = saved_reg;
    else if (wr_flags)
      flags_next = i_wdata[cfs_pkg::FLAG_W-1:0];
    else if (i_alu.valid)
    begin
      if (i_alu.mask[0])
        flags_next[cfs_pkg::BIT_C] = i_alu.carry;
      if (i_alu.mask[1])
        flags_next[cfs_pkg::BIT_Z] = i_alu.zero;
      if (i_alu.mask[2])
        flags_next[cfs_pkg::BIT_S] = i_alu.sign;
      if (i_alu.mask[3])
        flags_next[cfs_pkg::BIT_O] = i_alu.ovf;
    end
    if (i_ack.ack)
      flags_next[cfs_pkg::BIT_I] = 1'b0;
    if (ack_u_clr)
      flags_next[cfs_pkg::BIT_U] = 1'b0;
  end

  // ------------------------------------------------------------
  // save state
  // ------------------------------------------------------------
  always_comb
  begin
    case (state_reg)
      cfs_pkg::ST_RUN:   state_next = i_ack.ack ? cfs_pkg::ST_SAVED : cfs_pkg::ST_RUN;
      cfs_pkg::ST_SAVED: state_next = i_ret ? cfs_pkg::ST_RET : cfs_pkg::ST_SAVED;
      cfs_pkg::ST_RET:   state_next = i_ack.ack ? cfs_pkg::ST_SAVED : cfs_pkg::ST_RUN;
      default:           state_next = cfs_pkg::ST_RUN;
    endcase
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_comb
  begin
    rdata_next = '0;
    case (i_addr)
      cfs_pkg::OFF_FLAGS: rdata_next = {5'h00, flags_reg};
      cfs_pkg::OFF_SAVED: rdata_next = {5'h00, saved_reg};
      cfs_pkg::OFF_ISP:   rdata_next = '0;
      cfs_pkg::OFF_USP:   rdata_next = '0;
      cfs_pkg::OFF_STAT:  rdata_next = {13'h0000, state_reg};
      default:            rdata_next = '0;
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      flags_reg <= cfs_pkg::FLAGS_RST;
      saved_reg <= cfs_pkg::FLAGS_RST;
      state_reg <= cfs_pkg::ST_RUN;
    end
    else
    begin
      flags_reg <= flags_next;
      state_reg <= state_next;
      if (i_ack.ack)
        saved_reg <= flags_reg;
    end
  end

  logic rd_sp_reg;
  logic [cfs_pkg::DATA_W-1:0] rd_reg;

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rd_sp_reg    <= 1'b0;
      rd_reg       <= '0;
      o_irq_accept <= 1'b0;
    end
    else
    begin
      rd_sp_reg    <= i_rd & (i_addr == cfs_pkg::OFF_ISP || i_addr == cfs_pkg::OFF_USP);
      rd_reg       <= i_rd ? rdata_next : '0;
      o_irq_accept <= accept;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign o_flags = flags_reg;
  assign o_bank  = flags_reg[cfs_pkg::BIT_B];
  assign o_sp    = sp_rdata;
  assign o_rdata = rd_sp_reg ? sp_rdata : rd_reg;

  // ------------------------------------------------------------
  // children
  // ------------------------------------------------------------
  cfs_prio_cmp u_prio (
    .i_req      (i_irq_req),
    .i_req_prio (i_irq_prio),
    .i_ie       (flags_reg[cfs_pkg::BIT_I]),
    .i_ipl      (processor_priority_level),
    .o_accept   (accept)
  );

  cfs_sp_bank u_sp (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_wr      (sp_wr),
    .i_sel     (sp_sel),
    .i_wdata   (sp_wdata),
    .i_rsel    (rsel),
    .o_rdata   (sp_rdata)
  );
endmodule

// ---- tb/cfs_status_reg_asserts.sv ----
`timescale 1ns/1ps
module cfs_status_reg_asserts (
  // clock and reset
  input wire logic              i_sys_clk,
  input wire logic              i_rst_n,
  // inputs
  input wire logic [3:0]        i_addr,
  input wire logic [15:0]       i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic              i_ret,
  input wire logic              i_irq_req,
  input wire logic [2:0]        i_irq_prio,
  input wire cfs_pkg::cfs_alu_t i_alu,
  input wire cfs_pkg::cfs_ack_t i_ack,
  // outputs
  input wire logic [15:0]       o_rdata,
  input wire logic [10:0]       o_flags,
  input wire logic              o_bank,
  input wire logic              o_irq_accept
);
  wire quiet = !i_ret && !(i_wr && i_addr == 4'h0);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  a_bank_mirror: assert property (i_wr && i_addr == 4'h0 && !i_ret
    |=> o_bank == $past(i_wdata[4])) else $error("bank differs");
  a_ack_ie: assert property (i_ack.ack |=> !o_flags[6])
    else $error("ie kept");
  a_ack_stack: assert property (i_ack.ack && (i_ack.hw || i_ack.num < 6'h20)
    |=> !o_flags[7]) else $error("stack select kept");
  a_irq_gate: assert property (o_irq_accept ==
    $past(i_irq_req && o_flags[6] && (i_irq_prio > o_flags[10:8]))) else $error("accept wrong");
  a_carry_upd: assert property (quiet && i_alu.valid && i_alu.mask[0]
    |=> o_flags[0] == $past(i_alu.carry)) else $error("carry wrong");
  a_zero_upd: assert property (quiet && i_alu.valid && i_alu.mask[1]
    |=> o_flags[2] == $past(i_alu.zero)) else $error("zero wrong");
  a_sign_upd: assert property (quiet && i_alu.valid && i_alu.mask[2]
    |=> o_flags[3] == $past(i_alu.sign)) else $error("sign wrong");
  a_ovf_upd: assert property (quiet && i_alu.valid && i_alu.mask[3]
    |=> o_flags[5] == $past(i_alu.ovf)) else $error("overflow wrong");
  a_flag_hold: assert property (quiet && !i_alu.valid |=> $stable(o_flags[5:0]))
    else $error("flags moved");
  a_read_flags: assert property (i_rd && i_addr == 4'h0
    |=> o_rdata == {5'h00, $past(o_flags)}) else $error("read wrong");
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic              i_sys_clk, i_rst_n, i_wr, i_rd, i_ret, i_irq_req, i_sp_wr, rd_seen;
  logic [3:0]        i_addr, rq;
  logic [2:0]        i_irq_prio;
  logic [15:0]       i_wdata, i_sp_wdata, o_rdata, o_sp, p[2], exp_q[$];
  logic [10:0]       o_flags, m, w;
  logic              o_bank, o_irq_accept;
  logic [6:0]        akind[4] = '{7'h40, 7'h1f, 7'h20, 7'h00};
  cfs_pkg::cfs_alu_t i_alu, u;
  cfs_pkg::cfs_ack_t i_ack;
  int                error_cnt = 0, cmp_count = 0, seed = 92, k;

  cfs_status_reg i_dut (.i_sys_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_alu, .i_irq_req, .i_irq_prio, .i_ack, .i_ret, .i_sp_wr, .i_sp_wdata, .o_flags,
    .o_bank, .o_irq_accept, .o_sp);

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input logic wv, input logic rv, input logic tv, input logic [3:0] a,
                     input logic [15:0] d, input cfs_pkg::cfs_alu_t al,
                     input cfs_pkg::cfs_ack_t ak);
    i_wr <= wv;
    i_rd <= rv;
    i_ret <= tv;
    i_addr <= a;
    i_wdata <= d;
    i_alu <= al;
    i_ack <= ak;
    @(posedge i_sys_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    cyc(1'b1, 1'b0, 1'b0, a, d, '0, '0);
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    cyc(1'b0, 1'b1, 1'b0, a, 16'h0000, '0, '0);
  endtask

  task automatic summarize;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge i_sys_clk)
  begin
    if (rd_seen)
      chk(o_rdata, exp_q.pop_front());
    rd_seen <= i_rd;
  end

  initial
  begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  initial
  begin
    #200000;
    error_cnt++;
    summarize;
  end

  initial
  begin
    {i_rst_n, i_wr, i_rd, i_ret, i_irq_req, i_sp_wr, rd_seen} = '0;
    {i_addr, i_irq_prio, i_wdata, i_sp_wdata, i_alu, i_ack} = '0;
    repeat (4) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    for (k = 0; k < 4; k++)
      rd(k[3:0], 16'h0000);
    for (k = 0; k < 8; k++)
    begin
      m = 11'($random(seed)) & 11'h7fd;
      wr(4'h0, {5'h00, m});
      wr(4'h9, 16'hffff);
      wr(4'h1, 16'hffff);
      rd(4'h9, 16'h0000);
      rd(4'h1, 16'h0000);
      rd(4'h0, {5'h00, m});
      chk({15'h0, o_bank}, {15'h0, m[4]});
      chk({5'h00, o_flags}, {5'h00, m});
    end
    for (k = 0; k < 40; k++)
    begin
      u = 10'($random(seed));
      u.valid = 1'b1;
      cyc(1'b0, 1'b0, 1'b0, 4'h0, 16'h0000, u, '0);
      if (u.mask[0]) m[0] = u.carry;
      if (u.mask[1]) m[2] = u.zero;
      if (u.mask[2]) m[3] = u.sign;
      if (u.mask[3]) m[5] = u.ovf;
      rd(4'h0, {5'h00, m});
    end
    for (k = 0; k < 4; k++)
    begin
      w = (11'($random(seed)) | 11'h0c0) & 11'h7fd;
      wr(4'h0, {5'h00, w});
      cyc(1'b0, 1'b0, 1'b0, 4'h0, 16'h0000, '0, {1'b1, akind[k]});
      m = w;
      m[6] = 1'b0;
      m[7] = ~akind[k][6] & (akind[k][5:0] > 6'h1f);
      rd(4'h0, {5'h00, m});
      rd(4'h1, {5'h00, w});
      rd(4'h4, 16'h0002);
      cyc(1'b0, 1'b0, 1'b1, 4'h0, 16'h0000, '0, '0);
      rd(4'h4, 16'h0004);
      rd(4'h0, {5'h00, w});
    end
    for (k = 0; k < 48; k++)
    begin
      w = 11'($random(seed)) & 11'h7c0;
      rq = 4'($random(seed));
      wr(4'h0, {5'h00, w});
      i_irq_req <= rq[3];
      i_irq_prio <= rq[2:0];
      cyc(1'b0, 1'b0, 1'b0, 4'h0, 16'h0000, '0, '0);
      @(negedge i_sys_clk);
      chk({15'h0, o_irq_accept}, {15'h0, rq[3] & w[6] & (rq[2:0] > w[10:8])});
      @(posedge i_sys_clk);
    end
    p[0] = 16'($random(seed));
    p[1] = 16'($random(seed));
    wr(4'h2, p[0]);
    wr(4'h3, p[1]);
    for (k = 0; k < 2; k++)
    begin
      wr(4'h0, {8'h00, k[0], 7'h00});
      p[k] = 16'($random(seed));
      i_sp_wdata <= p[k];
      i_sp_wr <= 1'b1;
      cyc(1'b0, 1'b0, 1'b0, 4'h0, 16'h0000, '0, '0);
      i_sp_wr <= 1'b0;
      rd(4'h2, p[0]);
      rd(4'h3, p[1]);
      cyc(1'b0, 1'b0, 1'b0, 4'h0, 16'h0000, '0, '0);
      @(negedge i_sys_clk);
      chk(o_sp, p[k]);
      @(posedge i_sys_clk);
    end
    repeat (3) @(posedge i_sys_clk);
    summarize;
  end
endmodule

bind cfs_status_reg cfs_status_reg_asserts i_chk (.i_sys_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr,
  .i_rd, .i_ret, .i_irq_req, .i_irq_prio, .i_alu, .i_ack, .o_rdata, .o_flags, .o_bank,
  .o_irq_accept);
